// ### rtl/apfc_pkg.sv

// ============================================================
// Shared constants of the amplifier protection block
package apfc_pkg;

    // ========================================================
    // Clock and timing
    localparam int unsigned CLK_KHZ      = 20000;              // System clock in kHz
    localparam int unsigned DC_TRIP_MS   = 420;                // DC persistence time, ms
    localparam int unsigned DC_TRIP_CYC  = DC_TRIP_MS * CLK_KHZ; // Persistence in cycles
    localparam int unsigned DC_CNT_W     = 24;                 // Persistence counter width
    localparam int unsigned DC_DEV_PCT   = 14;                 // Differential duty limit, %

    // ========================================================
    // Modulator
    localparam int unsigned PWM_PERIOD   = 80;                 // Carrier period, cycles
    localparam int unsigned PWM_CNT_W    = 8;                  // Carrier counter width
    localparam int unsigned SAMPLE_W     = 8;                  // Signed audio sample width
    localparam int unsigned CAP_W        = 6;                  // Power cap level width
    localparam int unsigned PCAP_GAIN    = 4;                  // Virtual rail per cap step

    // ========================================================
    // Thermal
    localparam int unsigned TEMP_W       = 8;                  // Die temperature code, deg C
    localparam int unsigned THERM_TRIP_C = 150;                // Shutdown above this
    localparam int unsigned THERM_HYST_C = 15;                 // Cooling needed to resume

    // ========================================================
    // Channels and reset values
    localparam int unsigned NUM_CH       = 2;                  // Stereo
    localparam int unsigned CH_LEFT      = 0;                  // Left channel index
    localparam int unsigned CH_RIGHT     = 1;                  // Right channel index
    localparam logic        OE_N_RST     = 1'h1;               // Bridge hi-Z at reset
    localparam logic        ALARM_N_RST  = 1'h1;               // Alarm released at reset

    // Operating state of the output stage
    typedef enum logic [1:0] {
        APFC_ST_OFF   = 2'b00,   // Shutdown input low
        APFC_ST_RUN   = 2'b01,   // Bridges switching
        APFC_ST_HOT   = 2'b10,   // Thermal shutdown
        APFC_ST_FAULT = 2'b11    // DC or short latch set
    } apfc_state_t;

endpackage : apfc_pkg

// ### rtl/apfc_pwm_mod.sv
`timescale 1ns/1ps
// ============================================================
// Filter-free bridge modulator for one channel
module apfc_pwm_mod #(
    parameter int unsigned PERIOD = apfc_pkg::PWM_PERIOD,  // Carrier period
    parameter int unsigned SW     = apfc_pkg::SAMPLE_W,    // Sample width
    parameter int unsigned CW     = apfc_pkg::PWM_CNT_W    // Counter width
) (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          resetn,
    // Audio and limit
    input  wire logic signed [SW-1:0]          sample,
    input  wire logic [apfc_pkg::CAP_W-1:0]    cap_level,
    // Bridge waveforms
    output logic                               wave_pos,
    output logic                               wave_neg,
    // Deviation of the current period
    output logic                               dev_flag,
    output logic                               dev_pol
);
    import apfc_pkg::*;

    localparam logic [CW-1:0] HALF = CW'(PERIOD / 2);   // Half period
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);   // Last carrier step

    // All state of the modulator
    typedef struct packed {
        logic [CW-1:0] cnt;      // Carrier position
        logic [CW-1:0] mag;      // Duty offset magnitude
        logic          pol;      // Offset sign, 1 = positive
        logic          wpos;     // Positive output level
        logic          wneg;     // Negative output level
        logic          dev;      // Deviation above threshold
        logic          dpol;     // Sign of that deviation
    } apfc_mod_t;

    apfc_mod_t st_ff;            // Registered state
    apfc_mod_t nxt_st;           // Next state

    // Magnitude of sample clamped to the power-cap rail and half period
    function automatic logic [CW-1:0] clamp_mag(input logic signed [SW-1:0] s,
                                                input logic [CAP_W-1:0]    c);
        logic [SW:0]   a;
        logic [CW+7:0] lim;
        a   = s[SW-1] ? ((SW+1)'(0) - {s[SW-1], s}) : {1'h0, s};
        lim = (CW+8)'(32'(c) * PCAP_GAIN);
        if (lim > (CW+8)'(HALF)) begin
            lim = (CW+8)'(HALF);
        end
        if ((CW+8)'(a) < lim) begin
            lim = (CW+8)'(a);
        end
        return CW'(lim);
    endfunction

    // Differential duty 2*mag/PERIOD above the DC percentage
    function automatic logic above_dev(input logic [CW-1:0] m);
        logic [31:0] lhs;
        lhs = 32'(m) * 32'h0000_00C8;
        return lhs > 32'(DC_DEV_PCT * PERIOD);
    endfunction

    logic [CW-1:0] lim_mag;      // Clamped offset for next period
    logic [CW-1:0] thr_pos;      // Positive output high while cnt below
    logic [CW-1:0] thr_neg;      // Negative output high while cnt below

    // Next-state logic
    always_comb begin
        nxt_st  = st_ff;
        lim_mag = clamp_mag(sample, cap_level);
        // Outputs share one carrier: equal thresholds give in-phase edges
        thr_pos = st_ff.pol ? (HALF + st_ff.mag) : (HALF - st_ff.mag);
        thr_neg = st_ff.pol ? (HALF - st_ff.mag) : (HALF + st_ff.mag);
        nxt_st.wpos = st_ff.cnt < thr_pos;
        nxt_st.wneg = st_ff.cnt < thr_neg;
        // Carrier wrap loads the next period's offset
        if (st_ff.cnt == LAST) begin
            nxt_st.cnt  = '0;
            nxt_st.mag  = lim_mag;
            nxt_st.pol  = !sample[SW-1];
            nxt_st.dev  = above_dev(lim_mag);
            nxt_st.dpol = !sample[SW-1];
        end else begin
            nxt_st.cnt  = st_ff.cnt + 1'h1;
        end
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wave_pos = st_ff.wpos;
    assign wave_neg = st_ff.wneg;
    assign dev_flag = st_ff.dev;
    assign dev_pol  = st_ff.dpol;

endmodule // apfc_pwm_mod

// ### rtl/apfc_top.sv
`timescale 1ns/1ps
// ============================================================
// Amplifier protection and output-mode control
module apfc_top #(
    parameter int unsigned DC_TRIP = apfc_pkg::DC_TRIP_CYC,  // DC persistence, cycles
    parameter int unsigned PERIOD  = apfc_pkg::PWM_PERIOD    // Carrier period
) (
    // Clock and power-up reset
    input  wire logic                                  sys_clk,
    input  wire logic                                  resetn,
    // Controller straps
    input  wire logic                                  shutdown_n,
    input  wire logic                                  parallel_bridge_select,
    input  wire logic [apfc_pkg::CAP_W-1:0]            power_cap_level,
    // Audio samples
    input  wire logic signed [apfc_pkg::SAMPLE_W-1:0]  left_sample,
    input  wire logic signed [apfc_pkg::SAMPLE_W-1:0]  right_sample,
    // Sensors
    input  wire logic [apfc_pkg::NUM_CH-1:0]           over_current,
    input  wire logic [apfc_pkg::TEMP_W-1:0]           die_temp,
    // Bridge outputs
    output logic [apfc_pkg::NUM_CH-1:0]                bridge_out_pos,
    output logic [apfc_pkg::NUM_CH-1:0]                bridge_out_neg,
    output logic                                       bridge_oe_n,
    // Alarm
    output logic                                       fault_alarm_n
);
    import apfc_pkg::*;

    // ========================================================
    // Constants
    localparam logic [DC_CNT_W-1:0] TRIP_LIM   = DC_CNT_W'(DC_TRIP + 1);
    localparam logic [DC_CNT_W-1:0] CNT_ONE    = DC_CNT_W'(1);
    localparam logic [TEMP_W-1:0]   TEMP_TRIP  = TEMP_W'(THERM_TRIP_C);
    localparam logic [TEMP_W-1:0]   TEMP_CLEAR = TEMP_W'(THERM_TRIP_C - THERM_HYST_C);

    // ========================================================
    // State
    typedef struct packed {
        apfc_state_t                       state;     // Output-stage state
        logic                              dc_fault;  // DC latch, supply cycle only
        logic                              short_lat; // Short-circuit latch
        logic                              therm_sd;  // Thermal shutdown
        logic [NUM_CH-1:0]                 dc_pol;    // Polarity being timed
        logic [NUM_CH-1:0][DC_CNT_W-1:0]   dc_cnt;    // Persistence counters
        logic [NUM_CH-1:0]                 out_pos;   // Positive bridge levels
        logic [NUM_CH-1:0]                 out_neg;   // Negative bridge levels
        logic                              oe_n;      // Bridge enable, low drives
        logic                              alarm_n;   // Alarm level
    } apfc_core_t;

    apfc_core_t         st_ff;      // Registered state
    apfc_core_t         nxt_st;     // Next state
    logic [NUM_CH-1:0]  mod_pos;    // Modulator positive waves
    logic [NUM_CH-1:0]  mod_neg;    // Modulator negative waves
    logic [NUM_CH-1:0]  mod_dev;    // Deviation flags
    logic [NUM_CH-1:0]  mod_pol;    // Deviation polarity
    logic [NUM_CH-1:0]  ch_used;    // Channel under DC watch
    logic               trip_any;   // A counter has run past the limit
    logic               drive;      // Bridges switching next cycle

    // ========================================================
    // Modulators
    // Left modulator
    apfc_pwm_mod #(
        .PERIOD (PERIOD),
        .SW     (SAMPLE_W),
        .CW     (PWM_CNT_W)
    ) u_mod_left (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .sample    (left_sample),
        .cap_level (power_cap_level),
        .wave_pos  (mod_pos[CH_LEFT]),
        .wave_neg  (mod_neg[CH_LEFT]),
        .dev_flag  (mod_dev[CH_LEFT]),
        .dev_pol   (mod_pol[CH_LEFT])
    );

    // Right modulator, also the mono source
    apfc_pwm_mod #(
        .PERIOD (PERIOD),
        .SW     (SAMPLE_W),
        .CW     (PWM_CNT_W)
    ) u_mod_right (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .sample    (right_sample),
        .cap_level (power_cap_level),
        .wave_pos  (mod_pos[CH_RIGHT]),
        .wave_neg  (mod_neg[CH_RIGHT]),
        .dev_flag  (mod_dev[CH_RIGHT]),
        .dev_pol   (mod_pol[CH_RIGHT])
    );

    // ========================================================
    // Next-state logic
    always_comb begin
        nxt_st   = st_ff;
        trip_any = 1'h0;
        drive    = 1'h0;
        // Mono mode watches only the right channel
        ch_used  = parallel_bridge_select ? 2'h2 : 2'h3;

        // Thermal with hysteresis, clears on its own
        if (die_temp > TEMP_TRIP) begin
            nxt_st.therm_sd = 1'h1;
        end else if (die_temp <= TEMP_CLEAR) begin
            nxt_st.therm_sd = 1'h0;
        end

        // Short latch: shutdown low clears, a new overcurrent wins
        if (!shutdown_n) begin
            nxt_st.short_lat = 1'h0;
        end
        if ((st_ff.state == APFC_ST_RUN) && (|over_current)) begin
            nxt_st.short_lat = 1'h1;
        end

        // DC persistence timers, run only while switching
        for (int ch = 0; ch < NUM_CH; ch++) begin
            if (st_ff.dc_cnt[ch] == TRIP_LIM) begin
                trip_any = 1'h1;
            end
            if ((st_ff.state != APFC_ST_RUN) || !ch_used[ch] || !mod_dev[ch]) begin
                // Idle, unwatched in mono or back within threshold
                nxt_st.dc_cnt[ch] = '0;
            end else if ((st_ff.dc_cnt[ch] == '0) || (mod_pol[ch] != st_ff.dc_pol[ch])) begin
                // New deviation or polarity reversal restarts
                nxt_st.dc_cnt[ch] = CNT_ONE;
                nxt_st.dc_pol[ch] = mod_pol[ch];
            end else if (st_ff.dc_cnt[ch] != TRIP_LIM) begin
                // Same polarity persists
                nxt_st.dc_cnt[ch] = st_ff.dc_cnt[ch] + CNT_ONE;
            end
        end

        // DC fault never clears short of a power-up reset
        if (trip_any) begin
            nxt_st.dc_fault = 1'h1;
        end

        // Output-stage state, faults first
        if (nxt_st.dc_fault || nxt_st.short_lat) begin
            nxt_st.state = APFC_ST_FAULT;
        end else if (nxt_st.therm_sd) begin
            nxt_st.state = APFC_ST_HOT;
        end else if (!shutdown_n) begin
            nxt_st.state = APFC_ST_OFF;
        end else begin
            nxt_st.state = APFC_ST_RUN;
        end

        // Bridge drive
        case (nxt_st.state)
            APFC_ST_RUN: begin
                drive = 1'h1;
            end
            default: begin
                drive = 1'h0;
            end
        endcase
        nxt_st.oe_n = !drive;
        if (!drive) begin
            // Released bridges sit low behind the enable
            nxt_st.out_pos = '0;
            nxt_st.out_neg = '0;
        end else if (parallel_bridge_select) begin
            // Mono: each channel's pair moves together, right is the source
            nxt_st.out_pos[CH_LEFT]  = mod_pos[CH_RIGHT];
            nxt_st.out_neg[CH_LEFT]  = mod_pos[CH_RIGHT];
            nxt_st.out_pos[CH_RIGHT] = mod_neg[CH_RIGHT];
            nxt_st.out_neg[CH_RIGHT] = mod_neg[CH_RIGHT];
        end else begin
            // Stereo: independent bridges
            nxt_st.out_pos = mod_pos;
            nxt_st.out_neg = mod_neg;
        end

        // Alarm from DC and short only, never thermal
        nxt_st.alarm_n = !(nxt_st.dc_fault || nxt_st.short_lat);
    end

    // ========================================================
    // State register, power-up reset
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            st_ff         <= '0;
            st_ff.oe_n    <= OE_N_RST;
            st_ff.alarm_n <= ALARM_N_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ========================================================
    // Outputs
    assign bridge_out_pos = st_ff.out_pos;
    assign bridge_out_neg = st_ff.out_neg;
    assign bridge_oe_n    = st_ff.oe_n;
    assign fault_alarm_n  = st_ff.alarm_n;

    // ========================================================
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // DC fault shows on alarm and releases bridges
    dc_alarm_hiz_a: assert property (st_ff.dc_fault |-> !fault_alarm_n && bridge_oe_n)
        else $error("dc fault without alarm or hi-z");

    // DC fault survives shutdown toggling
    dc_fault_hold_a: assert property (st_ff.dc_fault |=> st_ff.dc_fault)
        else $error("dc fault cleared");

    // DC fault rises only from an expired timer
    dc_trip_cause_a: assert property ($rose(st_ff.dc_fault) |-> $past(trip_any))
        else $error("dc fault without expired timer");

    // Polarity flip restarts the timer at one
    dc_restart_a: assert property ((st_ff.state == APFC_ST_RUN) && mod_dev[CH_LEFT]
        && (st_ff.dc_cnt[CH_LEFT] != '0) && (mod_pol[CH_LEFT] != st_ff.dc_pol[CH_LEFT])
        |=> st_ff.dc_cnt[CH_LEFT] == CNT_ONE)
        else $error("timer not restarted on polarity reversal");

    // Overcurrent while running sets the latch and alarm
    short_set_a: assert property ((st_ff.state == APFC_ST_RUN) && (|over_current)
        |=> st_ff.short_lat && !fault_alarm_n && bridge_oe_n)
        else $error("short latch not set");

    // Two low shutdown cycles clear the short latch
    short_clear_a: assert property (!shutdown_n [*2] |=> !st_ff.short_lat)
        else $error("short latch not cleared by shutdown");

    // Hot die releases the bridges next cycle
    therm_enter_a: assert property (die_temp > TEMP_TRIP |=> st_ff.therm_sd && bridge_oe_n)
        else $error("no thermal shutdown");

    // Cooled die leaves thermal shutdown
    therm_exit_a: assert property (st_ff.therm_sd && (die_temp <= TEMP_CLEAR)
        |=> !st_ff.therm_sd)
        else $error("thermal shutdown did not clear");

    // Thermal alone never pulls the alarm
    therm_no_alarm_a: assert property (st_ff.therm_sd && !st_ff.dc_fault && !st_ff.short_lat
        |-> fault_alarm_n)
        else $error("alarm asserted by thermal");

    // Mono pairs move together
    mono_phase_a: assert property (!bridge_oe_n && $past(parallel_bridge_select)
        |-> (bridge_out_pos == bridge_out_neg))
        else $error("mono outputs out of phase");

    // Shutdown low mutes the bridges
    shut_mute_a: assert property (!shutdown_n |=> bridge_oe_n)
        else $error("bridges driven during shutdown");

endmodule // apfc_top

// ### verif/apfc_ctrl_model.sv
`timescale 1ns/1ps
// ============================================================
// System controller on the far side: drives shutdown, reads alarm
module apfc_ctrl_model (
    // Bench commands
    shut_cmd_n,
    auto_rec,
    // Device side
    fault_alarm_n,
    shutdown_n
);
    input  wire logic shut_cmd_n;     // Commanded shutdown level
    input  wire logic auto_rec;       // Alarm wired to shutdown
    input  wire logic fault_alarm_n;  // Alarm from the device
    output logic      shutdown_n;     // Shutdown strap to the device

    // Alarm pulls shutdown low when the two pins are tied together
    assign shutdown_n = shut_cmd_n & (fault_alarm_n | ~auto_rec);
endmodule // apfc_ctrl_model

// ### verif/apfc_top_tb_top.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the amplifier protection block
module apfc_top_tb_top;
    import apfc_pkg::*;
    localparam int unsigned TRIP = 2000;         // Shortened DC persistence
    localparam int          H    = PWM_PERIOD/2; // Half carrier period
    logic                        sys_clk   = 1'h0;  // System clock
    logic                        resetn    = 1'h0;  // Power-up reset
    logic                        shut_cmd_n = 1'h0; // Commanded shutdown
    logic                        auto_rec  = 1'h0;  // Alarm-to-shutdown wiring
    logic                        shutdown_n;        // Shutdown strap
    logic                        pbs       = 1'h0;  // Mono select
    logic [CAP_W-1:0]            cap       = 6'h0A; // Cap level
    logic signed [SAMPLE_W-1:0]  ls        = 8'h00; // Left sample
    logic signed [SAMPLE_W-1:0]  rs        = 8'h00; // Right sample
    logic [NUM_CH-1:0]           oc        = 2'h0;  // Overcurrent
    logic [TEMP_W-1:0]           temp      = 8'h19; // Die temperature
    logic [NUM_CH-1:0]           pos;               // Positive bridge outputs
    logic [NUM_CH-1:0]           neg;               // Negative bridge outputs
    logic                        oe_n;              // Bridge enable
    logic                        alarm_n;           // Alarm
    int                          fail_count = 0;    // Mismatches
    int                          n_tests    = 0;    // Comparisons
    int                          cp[2];             // High cycles, positive
    int                          cn[2];             // High cycles, negative
    int                          eqp;               // Cycles with pos equal neg
    int                          n;                 // Wait length

    // ========================================================
    // Clock, design and partner
    always #25 sys_clk = ~sys_clk;

    apfc_top #(.DC_TRIP(TRIP), .PERIOD(PWM_PERIOD)) i_apfc_top (
        .sys_clk(sys_clk), .resetn(resetn), .shutdown_n(shutdown_n),
        .parallel_bridge_select(pbs), .power_cap_level(cap),
        .left_sample(ls), .right_sample(rs), .over_current(oc), .die_temp(temp),
        .bridge_out_pos(pos), .bridge_out_neg(neg), .bridge_oe_n(oe_n),
        .fault_alarm_n(alarm_n)
    );

    apfc_ctrl_model i_apfc_ctrl_model (
        .shut_cmd_n(shut_cmd_n), .auto_rec(auto_rec),
        .fault_alarm_n(alarm_n), .shutdown_n(shutdown_n)
    );

    // ========================================================
    // Helpers
    // Compares one value and counts
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Runs k edges, then settles at the falling edge
    task automatic at(input int k);
        repeat (k) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // Drives the commanded shutdown level at a rising edge, then runs k edges
    task automatic set_shut(input logic v, input int k);
        @(posedge sys_clk);
        shut_cmd_n <= v;
        at(k);
    endtask

    // Drives the die temperature at a rising edge, then runs three edges
    task automatic heat(input logic [TEMP_W-1:0] t);
        @(posedge sys_clk);
        temp <= t;
        at(3);
    endtask

    // Waits a bounded time for the alarm level
    task automatic wait_alarm(input logic want, input int lim);
        n = 0;
        while (alarm_n !== want && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        chk(alarm_n, want);
    endtask

    // Reference offset: magnitude clamped by cap and half period
    function automatic int mag(input int s, input int c);
        int m;
        m = (s < 0) ? -s : s;
        if (m > PCAP_GAIN*c) m = PCAP_GAIN*c;
        if (m > H) m = H;
        return m;
    endfunction

    // Applies samples, measures one carrier period, compares
    task automatic duty(input int l, input int r, input int c, input logic mono);
        int ml;
        int mr;
        @(posedge sys_clk);
        ls  <= l[7:0];
        rs  <= r[7:0];
        cap <= c[5:0];
        pbs <= mono;
        at(3*PWM_PERIOD);
        cp  = '{0, 0};
        cn  = '{0, 0};
        eqp = 0;
        repeat (PWM_PERIOD) begin
            @(negedge sys_clk);
            for (int ch = 0; ch < 2; ch++) begin
                cp[ch] += pos[ch];
                cn[ch] += neg[ch];
            end
            if (pos === neg) eqp++;
        end
        mr = mag(r, c);
        ml = mag(l, c);
        if (mono) begin
            chk(eqp, PWM_PERIOD);
            chk(cp[0], (r >= 0) ? H+mr : H-mr);
            chk(cp[1], (r >= 0) ? H-mr : H+mr);
        end else begin
            if (l == 0 && r == 0) chk(eqp, PWM_PERIOD);
            chk(cp[0], (l >= 0) ? H+ml : H-ml);
            chk(cn[0], (l >= 0) ? H-ml : H+ml);
            chk(cp[1], (r >= 0) ? H+mr : H-mr);
            chk(cn[1], (r >= 0) ? H-mr : H+mr);
        end
        @(posedge sys_clk);
        ls <= 8'h00;
        rs <= 8'h00;
        at(2*PWM_PERIOD);
    endtask

    // Prints counts and verdict, ends the run
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ========================================================
    // Watchdog
    initial begin
        #(50*60000);
        fail_count++;
        wrap_up();
    end

    // ========================================================
    // Main sequence, inputs move just after the rising edge
    initial begin
        void'($urandom(2614));
        // Shutdown held low through power-up
        at(15);
        chk({oe_n, alarm_n, pos, neg}, 6'h30);
        @(posedge sys_clk);
        resetn <= 1'h1;
        at(4);
        chk(oe_n, 1'h1);
        set_shut(1'h1, 3);
        chk(oe_n, 1'h0);
        // Modulation, cap and mode
        duty(0, 0, 10, 1'h0);
        duty(30, -7, 2, 1'h0);
        duty(-25, 45, 15, 1'h0);
        for (int i = 0; i < 6; i++)
            duty(int'($urandom_range(100)) - 50, int'($urandom_range(100)) - 50,
                 int'($urandom_range(15)), i[0]);
        // DC timer restart on polarity flip, then trip; cap wide enough to deviate
        @(posedge sys_clk);
        pbs <= 1'h0;
        cap <= 6'h0A;
        ls  <= 8'h14;
        at(TRIP - 2*PWM_PERIOD);
        @(posedge sys_clk);
        ls <= 8'hEC;
        at(TRIP - 2*PWM_PERIOD);
        chk(alarm_n, 1'h1);
        wait_alarm(1'h0, 4*PWM_PERIOD);
        // Trip lands at most three carrier periods plus two cycles after the timed span
        chk((TRIP - 2*PWM_PERIOD + n > TRIP) && (n <= 3*PWM_PERIOD + 2), 1'h1);
        at(1);
        chk({oe_n, pos, neg}, 5'h10);
        @(posedge sys_clk);
        ls <= 8'h00;
        set_shut(1'h0, 3);
        set_shut(1'h1, 4);
        chk({oe_n, alarm_n}, 2'h2);
        @(posedge sys_clk);
        resetn <= 1'h0;
        at(2);
        @(posedge sys_clk);
        resetn <= 1'h1;
        at(4);
        chk({oe_n, alarm_n}, 2'h1);
        // Short circuit latch and manual clear
        @(posedge sys_clk);
        oc <= 2'h2;
        @(posedge sys_clk);
        oc <= 2'h0;
        at(6);
        chk({oe_n, alarm_n, pos, neg}, 6'h20);
        set_shut(1'h0, 3);
        set_shut(1'h1, 3);
        chk({oe_n, alarm_n}, 2'h1);
        // Overcurrent while shut down is ignored
        set_shut(1'h0, 2);
        @(posedge sys_clk);
        oc <= 2'h3;
        at(1);
        chk(oe_n, 1'h1);
        @(posedge sys_clk);
        oc         <= 2'h0;
        shut_cmd_n <= 1'h1;
        at(3);
        chk({oe_n, alarm_n}, 2'h1);
        // Automatic recovery through alarm wiring
        @(posedge sys_clk);
        auto_rec <= 1'h1;
        oc       <= 2'h1;
        @(posedge sys_clk);
        oc <= 2'h0;
        at(0);
        wait_alarm(1'h0, 8);
        wait_alarm(1'h1, 8);
        at(3);
        chk(oe_n, 1'h0);
        @(posedge sys_clk);
        auto_rec <= 1'h0;
        // Thermal shutdown with hysteresis
        heat(8'h96);
        chk(oe_n, 1'h0);
        heat(8'h97);
        chk({oe_n, alarm_n}, 2'h3);
        heat(8'h88);
        chk(oe_n, 1'h1);
        heat(8'h87);
        chk({oe_n, alarm_n}, 2'h1);
        wrap_up();
    end
endmodule // apfc_top_tb_top
